// *** core/cod_top.sv ***
`include "cod_defs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - each channel divides by its programmed 30-bit value plus one
// - even ratios give equal high and low times
// - ratio one passes the input clock straight through
// - odd ratios above one stretch the high time by the input high fraction
// - correction moves the fall when normal, the rise when inverted
// - per-channel power-down bit turns that channel's driver off
// - both channels powered down puts the whole section to deep sleep
// - disable in cmos stalls the pin statically, divider stays in step
// - enable changes land only at divider period boundaries, no runts
// - each channel has a mode register, low three bits pick the family
// - codes: cmos both, cmos p, cmos n, tristate, lvds, lvpecl, two unused
// - polarity invert bit, default normal, flips sense for every family
// - cmos phase invert makes the negative pin the complement
// - drive bit picks weak or strong for cmos and lvds, lvpecl ignores it
// - settings bit 4 selects the high-frequency input receiver
// - mode register bit 3 is the drive strength control
// - settings bit 5 selects the external current-setting resistor
module cod_top #(
    parameter int DIV_W = `COD_DIV_W,
    parameter int AW = `COD_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic channel0_positive_pin_out,
    output logic channel0_positive_pin_oe,
    output logic channel0_negative_pin_out,
    output logic channel0_negative_pin_oe,
    output logic channel1_positive_pin_out,
    output logic channel1_positive_pin_oe,
    output logic channel1_negative_pin_out,
    output logic channel1_negative_pin_oe,
    output logic channel0_drive_strong,
    output logic channel1_drive_strong,
    output logic hf_receiver_sel,
    output logic current_set_resistor_ext_sel,
    output logic deep_sleep
);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] settings_q, settings_d;
    logic [7:0] enables_q, enables_d;
    logic [7:0] mode_q [2];
    logic [7:0] mode_d [2];
    logic [DIV_W-1:0] div_q [2];
    logic [DIV_W-1:0] div_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic [31:0] div_word [2];
    logic [1:0] ch_running;
    logic sleep_q, sleep_d;

    always_comb begin
        settings_d = settings_q;
        enables_d = enables_q;
        for (int c = 0; c < 2; c++) begin
            mode_d[c] = mode_q[c];
            div_d[c] = div_q[c];
            div_word[c] = {{(32-DIV_W){1'b0}}, div_q[c]};
        end
        if (reg_wr) begin
            case (reg_addr)
                `COD_OFS_SETTINGS: settings_d = reg_wdata;
                `COD_OFS_ENABLES: enables_d = reg_wdata;
                `COD_OFS_MODE0: mode_d[0] = reg_wdata;
                `COD_OFS_MODE1: mode_d[1] = reg_wdata;
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        for (int b = 0; b < 4; b++) begin
                            if (reg_addr == `COD_OFS_DIV0 + AW'(4 * c + b)) begin
                                div_word[c][8*b +: 8] = reg_wdata;
                                div_d[c] = div_word[c][DIV_W-1:0];
                            end
                        end
                    end
                end
            endcase
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `COD_OFS_SETTINGS: rdata_d = settings_q;
                `COD_OFS_ENABLES: rdata_d = enables_q;
                `COD_OFS_MODE0: rdata_d = mode_q[0];
                `COD_OFS_MODE1: rdata_d = mode_q[1];
                `COD_OFS_STATUS: begin
                    rdata_d[`COD_STAT_RUN0] = ch_running[0];
                    rdata_d[`COD_STAT_RUN1] = ch_running[1];
                    rdata_d[`COD_STAT_SLEEP] = sleep_q;
                end
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        for (int b = 0; b < 4; b++) begin
                            if (reg_addr == `COD_OFS_DIV0 + AW'(4 * c + b)) begin
                                rdata_d = div_word[c][8*b +: 8];
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settings_q <= `COD_RST_SETTINGS;
            enables_q <= `COD_RST_ENABLES;
            mode_q[0] <= `COD_RST_MODE;
            mode_q[1] <= `COD_RST_MODE;
            div_q[0] <= `COD_RST_DIV;
            div_q[1] <= `COD_RST_DIV;
            rdata_q <= 8'h00;
        end else begin
            settings_q <= settings_d;
            enables_q <= enables_d;
            mode_q <= mode_d;
            div_q <= div_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // deep sleep and level outputs

    logic [1:0] drive_q, drive_d;
    logic hf_q, hf_d;
    logic rset_q, rset_d;

    always_comb begin
        sleep_d = settings_q[`COD_SET_PD0] && settings_q[`COD_SET_PD1];
        for (int c = 0; c < 2; c++) begin
            // lvpecl has a fixed current, the bit is dropped there
            drive_d[c] = mode_q[c][`COD_MODE_DRIVE] &&
                (mode_q[c][`COD_MODE_MSB:`COD_MODE_LSB] != 3'h5);
        end
        hf_d = settings_q[`COD_SET_HF_RX];
        rset_d = settings_q[`COD_SET_EXT_RSET];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sleep_q <= 1'b0;
            drive_q <= 2'h0;
            hf_q <= 1'b0;
            rset_q <= 1'b0;
        end else begin
            sleep_q <= sleep_d;
            drive_q <= drive_d;
            hf_q <= hf_d;
            rset_q <= rset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel divider, gating state and pad

    logic [1:0] pos_q, neg_q, wrap, odd, bypass;
    cod_pkg::cod_chst_t st_q [2];
    cod_pkg::cod_chst_t st_d [2];
    logic [1:0] p_out, p_oe, n_out, n_oe;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            st_d[c] = st_q[c];
            case (st_q[c])
                cod_pkg::COD_CH_SLEEP: begin
                    if (!sleep_q) begin
                        st_d[c] = cod_pkg::COD_CH_STALL;
                    end
                end
                cod_pkg::COD_CH_STALL: begin
                    if (sleep_q) begin
                        st_d[c] = cod_pkg::COD_CH_SLEEP;
                    end else if (enables_q[c] && wrap[c]) begin
                        st_d[c] = cod_pkg::COD_CH_RUN;
                    end
                end
                cod_pkg::COD_CH_RUN: begin
                    if (sleep_q) begin
                        st_d[c] = cod_pkg::COD_CH_SLEEP;
                    end else if (!enables_q[c] && wrap[c]) begin
                        st_d[c] = cod_pkg::COD_CH_STALL;
                    end
                end
                default: st_d[c] = cod_pkg::COD_CH_SLEEP;
            endcase
            ch_running[c] = (st_q[c] == cod_pkg::COD_CH_RUN);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q[0] <= cod_pkg::COD_CH_STALL;
            st_q[1] <= cod_pkg::COD_CH_STALL;
        end else begin
            st_q <= st_d;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_ch
        cod_chan_if chan ();

        // both dividers leave sleep on the same edge, so equal ratios align
        cod_divider #(
            .W(DIV_W)
        ) u_div (
            .clk(clk),
            .rst(rst),
            .run(!sleep_q),
            .ratio_m1(div_q[c]),
            .pos_q(pos_q[c]),
            .neg_q(neg_q[c]),
            .wrap(wrap[c]),
            .odd(odd[c]),
            .bypass(bypass[c])
        );

        assign chan.mode = cod_pkg::cod_mode_t'(mode_q[c][`COD_MODE_MSB:`COD_MODE_LSB]);
        assign chan.pol_inv = mode_q[c][`COD_MODE_POL_INV];
        assign chan.phase_inv = mode_q[c][`COD_MODE_PHASE_INV];
        assign chan.power_down = settings_q[c];
        assign chan.run_en = ch_running[c];

        cod_pad u_pad (
            .clk(clk),
            .cfg(chan.pad),
            .pos_q(pos_q[c]),
            .neg_q(neg_q[c]),
            .odd(odd[c]),
            .bypass(bypass[c]),
            .p_out(p_out[c]),
            .p_oe(p_oe[c]),
            .n_out(n_out[c]),
            .n_oe(n_oe[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = rdata_q;
    // pin drivers come straight from the pad logic, unregistered, needed for ratio one and odd ratios
    assign channel0_positive_pin_out = p_out[0];
    assign channel0_positive_pin_oe = p_oe[0];
    assign channel0_negative_pin_out = n_out[0];
    assign channel0_negative_pin_oe = n_oe[0];
    assign channel1_positive_pin_out = p_out[1];
    assign channel1_positive_pin_oe = p_oe[1];
    assign channel1_negative_pin_out = n_out[1];
    assign channel1_negative_pin_oe = n_oe[1];
    assign channel0_drive_strong = drive_q[0];
    assign channel1_drive_strong = drive_q[1];
    assign hf_receiver_sel = hf_q;
    assign current_set_resistor_ext_sel = rset_q;
    assign deep_sleep = sleep_q;

endmodule : cod_top

`default_nettype wire

// *** core/cod_defs.svh ***
`ifndef COD_DEFS_SVH
`define COD_DEFS_SVH

// register byte addresses
`define COD_ADDR_W 12
`define COD_OFS_SETTINGS 12'h400
`define COD_OFS_ENABLES 12'h401
`define COD_OFS_MODE0 12'h404
`define COD_OFS_MODE1 12'h405
`define COD_OFS_DIV0 12'h406
`define COD_OFS_DIV1 12'h40a
`define COD_OFS_STATUS 12'h40e

// settings fields
`define COD_SET_PD0 0
`define COD_SET_PD1 1
`define COD_SET_HF_RX 4
`define COD_SET_EXT_RSET 5

// channel mode fields
`define COD_MODE_LSB 0
`define COD_MODE_MSB 2
`define COD_MODE_DRIVE 3
`define COD_MODE_POL_INV 4
`define COD_MODE_PHASE_INV 5

// status fields
`define COD_STAT_RUN0 0
`define COD_STAT_RUN1 1
`define COD_STAT_SLEEP 2

// reset values
`define COD_RST_SETTINGS 8'h00
`define COD_RST_ENABLES 8'h03
`define COD_RST_MODE 8'h00
`define COD_RST_DIV 30'h0000_0000

`define COD_DIV_W 30

`endif

// *** core/cod_pkg.sv ***
`default_nettype none

package cod_pkg;

    typedef enum logic [2:0] {
        COD_MODE_CMOS_BOTH = 3'h0,
        COD_MODE_CMOS_POS = 3'h1,
        COD_MODE_CMOS_NEG = 3'h2,
        COD_MODE_TRI_BOTH = 3'h3,
        COD_MODE_LVDS = 3'h4,
        COD_MODE_LVPECL = 3'h5,
        COD_MODE_UNUSED6 = 3'h6,
        COD_MODE_UNUSED7 = 3'h7
    } cod_mode_t;

    typedef enum logic [2:0] {
        COD_CH_SLEEP = 3'h1,
        COD_CH_STALL = 3'h2,
        COD_CH_RUN = 3'h4
    } cod_chst_t;

endpackage : cod_pkg

`default_nettype wire

// *** core/cod_chan_if.sv ***
`default_nettype none

interface cod_chan_if;
    cod_pkg::cod_mode_t mode;
    logic pol_inv;
    logic phase_inv;
    logic power_down;
    logic run_en;

    modport ctrl (
        output mode,
        output pol_inv,
        output phase_inv,
        output power_down,
        output run_en
    );

    modport pad (
        input mode,
        input pol_inv,
        input phase_inv,
        input power_down,
        input run_en
    );
endinterface : cod_chan_if

`default_nettype wire

// *** core/cod_divider.sv ***
`include "cod_defs.svh"
`default_nettype none

module cod_divider #(
    parameter int W = `COD_DIV_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [W-1:0] ratio_m1,
    output logic pos_q,
    output logic neg_q,
    output logic wrap,
    output logic odd,
    output logic bypass
);

    logic [W-1:0] cnt_q, cnt_d;
    logic [W-1:0] lim_q, lim_d;
    logic pos_d;
    logic [W:0] half;
    logic [W:0] half_new;

    always_comb begin
        half = ({1'b0, lim_q} + {{W{1'b0}}, 1'b1}) >> 1;
        half_new = ({1'b0, ratio_m1} + {{W{1'b0}}, 1'b1}) >> 1;
        wrap = run && (cnt_q == lim_q);
        cnt_d = cnt_q;
        lim_d = lim_q;
        pos_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
            lim_d = ratio_m1;
        end else if (cnt_q == lim_q) begin
            // new ratio only at a period boundary, so no short period
            cnt_d = '0;
            lim_d = ratio_m1;
            pos_d = (half_new != '0);
        end else begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
            pos_d = ({1'b0, cnt_d} < half);
        end
    end

    // ratio is lim+1: odd ratio above one when lim is even and nonzero
    assign odd = !lim_q[0] && (lim_q != '0);
    assign bypass = (lim_q == '0);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            lim_q <= `COD_RST_DIV;
            pos_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lim_q <= lim_d;
            pos_q <= pos_d;
        end
    end

    // half-period delayed copy, lets odd ratios stretch to a falling edge
    always_ff @(negedge clk) begin
        if (rst) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= pos_q;
        end
    end

endmodule : cod_divider

`default_nettype wire

// *** core/cod_pad.sv ***
`default_nettype none

module cod_pad (
    input wire logic clk,
    cod_chan_if.pad cfg,
    input wire logic pos_q,
    input wire logic neg_q,
    input wire logic odd,
    input wire logic bypass,
    output logic p_out,
    output logic p_oe,
    output logic n_out,
    output logic n_oe
);

    logic raw;
    logic sig;

    always_comb begin
        if (bypass) begin
            raw = clk;
        end else if (odd) begin
            // or-ing moves the fall; after inversion that is the rise
            raw = pos_q | neg_q;
        end else begin
            raw = pos_q;
        end
        // stalled channel sits low, or high when pol_inv is set, divider keeps counting
        sig = (cfg.run_en ? raw : 1'b0) ^ cfg.pol_inv;
        p_out = sig;
        n_out = sig;
        p_oe = 1'b0;
        n_oe = 1'b0;
        case (cfg.mode)
            cod_pkg::COD_MODE_CMOS_BOTH: begin
                n_out = sig ^ cfg.phase_inv;
                p_oe = 1'b1;
                n_oe = 1'b1;
            end
            cod_pkg::COD_MODE_CMOS_POS: begin
                p_oe = 1'b1;
            end
            cod_pkg::COD_MODE_CMOS_NEG: begin
                n_out = sig ^ cfg.phase_inv;
                n_oe = 1'b1;
            end
            cod_pkg::COD_MODE_LVDS, cod_pkg::COD_MODE_LVPECL: begin
                n_out = ~sig;
                p_oe = 1'b1;
                n_oe = 1'b1;
            end
            default: begin
                p_oe = 1'b0;
                n_oe = 1'b0;
            end
        endcase
        if (cfg.power_down) begin
            p_oe = 1'b0;
            n_oe = 1'b0;
        end
    end

endmodule : cod_pad

`default_nettype wire

// *** test/cod_top_sva.sv ***
`default_nettype none

////////////////////////////////////////
module cod_top_sva #(
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic channel0_positive_pin_oe,
    input wire logic channel0_negative_pin_oe,
    input wire logic channel1_positive_pin_oe,
    input wire logic channel1_negative_pin_oe,
    input wire logic channel0_drive_strong,
    input wire logic hf_receiver_sel,
    input wire logic current_set_resistor_ext_sel,
    input wire logic deep_sleep
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a write followed by two quiet cycles at the same address
    sequence s_set(a);
        (reg_wr && reg_addr == a) ##1 (!(reg_wr && reg_addr == a))[*2];
    endsequence
    sequence s_wr_then_rd(a);
        (reg_wr && reg_addr == a) ##1 (!(reg_wr && reg_addr == a))[*4]
            ##1 (reg_rd && reg_addr == a);
    endsequence

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read reply");
    a_unmapped_read: assert property ((reg_rd && (reg_addr < 12'h400
        || reg_addr > 12'h40e || reg_addr == 12'h402 || reg_addr == 12'h403))
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_enable_readback: assert property (s_wr_then_rd(12'h401) |=>
        reg_rdata[1:0] == $past(reg_wdata[1:0], 6))
        else $error("enable bits do not read back");
    a_drive_follows: assert property (s_set(12'h404) |=>
        channel0_drive_strong == ($past(reg_wdata[3], 3) && ($past(reg_wdata[2:0], 3) != 3'h5)))
        else $error("drive strength does not follow mode");
    a_hf_follows: assert property (s_set(12'h400) |=>
        hf_receiver_sel == $past(reg_wdata[4], 3))
        else $error("receiver select does not follow settings");
    a_rset_follows: assert property (s_set(12'h400) |=>
        current_set_resistor_ext_sel == $past(reg_wdata[5], 3))
        else $error("resistor select does not follow settings");
    a_sleep_follows: assert property (s_set(12'h400) |=>
        deep_sleep == ($past(reg_wdata[1:0], 3) == 2'h3))
        else $error("deep sleep does not match both power-down bits");
    // the flag lags the power-down bits a cycle, so a driven pin must end it next cycle
    a_sleep_quiet: assert property ((deep_sleep && (channel0_positive_pin_oe
        || channel0_negative_pin_oe || channel1_positive_pin_oe
        || channel1_negative_pin_oe)) |=> !deep_sleep)
        else $error("pin driven while deep sleep holds");
    a_tristate_code: assert property (s_set(12'h404) |=>
        !($past(reg_wdata[2:0], 3) inside {3'h3, 3'h6, 3'h7})
        || !(channel0_positive_pin_oe || channel0_negative_pin_oe))
        else $error("pin driven in a tristate or unused mode");
endmodule : cod_top_sva

bind cod_top cod_top_sva #(.AW(AW)) chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .channel0_positive_pin_oe(channel0_positive_pin_oe),
    .channel0_negative_pin_oe(channel0_negative_pin_oe),
    .channel1_positive_pin_oe(channel1_positive_pin_oe),
    .channel1_negative_pin_oe(channel1_negative_pin_oe),
    .channel0_drive_strong(channel0_drive_strong), .hf_receiver_sel(hf_receiver_sel),
    .current_set_resistor_ext_sel(current_set_resistor_ext_sel), .deep_sleep(deep_sleep));

`default_nettype wire

// *** test/cod_load_model.sv ***
`default_nettype none

////////////////////////////////////////
module cod_load_model (
    input wire logic pin,
    input wire logic oe,
    output int period_ns,
    output int high_ns,
    output int rises
);
    timeunit 1ns;
    timeprecision 100ps;
    time last_rise = 0;
    initial begin
        period_ns = 0;
        high_ns = 0;
        rises = 0;
    end
    // a released pin carries no clock, so only driven edges count
    always @(posedge pin) begin
        if (oe) begin
            period_ns = int'($time - last_rise);
            last_rise = $time;
            rises = rises + 1;
        end
    end
    always @(negedge pin) begin
        if (oe) begin
            high_ns = int'($time - last_rise);
        end
    end
endmodule : cod_load_model

`default_nettype wire

// *** test/cod_top_tb_top.sv ***
`default_nettype none

////////////////////////////////////////
module cod_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic p0, p0_oe, n0, n0_oe, p1, p1_oe, n1, n1_oe, ds0, ds1, hf, ext, sleep;
    int fails = 0;
    int n_tests = 0;
    int per0, hi0, cnt0, per1, hi1, cnt1, e;
    logic [1:0] oe_tab [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};

    cod_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel0_positive_pin_out(p0), .channel0_positive_pin_oe(p0_oe),
        .channel0_negative_pin_out(n0), .channel0_negative_pin_oe(n0_oe),
        .channel1_positive_pin_out(p1), .channel1_positive_pin_oe(p1_oe),
        .channel1_negative_pin_out(n1), .channel1_negative_pin_oe(n1_oe),
        .channel0_drive_strong(ds0), .channel1_drive_strong(ds1), .hf_receiver_sel(hf),
        .current_set_resistor_ext_sel(ext), .deep_sleep(sleep));
    cod_load_model load0_u (.pin(p0), .oe(p0_oe), .period_ns(per0), .high_ns(hi0),
        .rises(cnt0));
    cod_load_model load1_u (.pin(p1), .oe(p1_oe), .period_ns(per1), .high_ns(hi1),
        .rises(cnt1));

    always #10 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    // bytes land one at a time, so the divider may run an odd ratio briefly
    task automatic wdiv(input logic [11:0] base, input logic [29:0] v);
        logic [31:0] x;
        x = {2'h0, v};
        for (int i = 0; i < 4; i++) wr(base + 12'(i), x[8*i +: 8]);
    endtask : wdiv

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(12'h400, 8'h00);
        rd(12'h401, 8'h03);
        rd(12'h404, 8'h00);
        rd(12'h405, 8'h00);
        rd(12'h40e, 8'h03);
        wr(12'h403, 8'hff);
        rd(12'h403, 8'h00);
        $display("test reset done");
        wdiv(12'h406, 30'h3);
        wdiv(12'h40a, 30'h4);
        rd(12'h40a, 8'h04);
        repeat (30) @(posedge clk);
        chk(per0, 80);
        chk(hi0, 40);
        chk(per1, 100);
        chk(hi1, 50);
        wr(12'h405, 8'h10);
        repeat (30) @(posedge clk);
        chk(per1, 100);
        chk(hi1, 50);
        wr(12'h405, 8'h00);
        wdiv(12'h406, 30'h0);
        repeat (10) @(posedge clk);
        chk(per0, 20);
        chk(hi0, 10);
        $display("test ratios done");
        wr(12'h401, 8'h01);
        rd(12'h401, 8'h01);
        repeat (10) @(posedge clk);
        e = cnt1;
        repeat (20) @(posedge clk);
        chk(cnt1, e);
        chk(p1, 1'h0);
        wr(12'h405, 8'h10);
        chk(p1, 1'h1);
        wr(12'h405, 8'h00);
        wr(12'h401, 8'h03);
        repeat (30) @(posedge clk);
        chk(cnt1 > e + 2, 1'h1);
        chk(hi1, 50);
        $display("test enables done");
        for (int m = 0; m < 8; m++) begin
            wr(12'h404, 8'(m) | 8'h08);
            chk({p0_oe, n0_oe}, oe_tab[m]);
            chk(ds0, m != 5);
        end
        wr(12'h405, 8'h0c);
        chk(ds1, 1'h1);
        // a quarter cycle in, clear of the clock edge and the half-period flop
        #5 chk(n1, !p1);
        wr(12'h404, 8'h20);
        for (int k = 0; k < 3; k++) begin
            #7 chk(n0, !p0);
        end
        wr(12'h404, 8'h00);
        #5 chk({n0, ds0}, {p0, 1'h0});
        $display("test modes done");
        wr(12'h400, 8'h30);
        chk({hf, ext}, 2'h3);
        wr(12'h400, 8'h01);
        chk({p0_oe, n0_oe, p1_oe, n1_oe, sleep}, 5'h06);
        wr(12'h400, 8'h03);
        repeat (3) @(posedge clk);
        chk({p0_oe, n0_oe, p1_oe, n1_oe, sleep}, 5'h01);
        rd(12'h400, 8'h03);
        rd(12'h40e, 8'h04);
        wr(12'h400, 8'h00);
        chk(sleep, 1'h0);
        // top divider byte keeps only the low six bits of the 30-bit value
        wr(12'h409, 8'hff);
        rd(12'h409, 8'h3f);
        $display("test settings done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        summarize();
    end
endmodule : cod_top_tb_top

`default_nettype wire
